// ---- include/adtp_pkg.sv ----
// Shared constants and types for both ends of the serial port link
//
// Behaviour
// - Sign-on unit with abort flag raises nexus loss
// - ACK to sent device reset raises nexus loss
// - Reset indication from interconnect raises nexus loss
// - Closed while signing on/signed on: nexus loss
// - Close event returns port to start state
// - Recompute ack time-out on parameter change
// - Ethernet port starts with 2.5 s time-out
// - Time-out unit may replace Ethernet time-out
// - Each lane runs 9600 baud mandatory
// - NRZ coding, bit rate equals baud rate
// - One start, one stop, no parity bit
// - Each lane is one-direction, two for duplex
// - Drive monitors automation presence sense input
// - Automation device monitors drive presence sense
// - Automation device may assert reset request line
// - Drive turns reset line into reset indication
// - Automation transmits on host-to-drive lane
// - Drive transmits on drive-to-host lane
package adtp_pkg;
    localparam int unsigned CLK_MHZ        = 200;
    localparam int unsigned BAUD_RATE      = 9600;
    localparam int unsigned BAUD_DIV_CYC   = CLK_MHZ * 1000000 / BAUD_RATE;
    localparam int unsigned ACK_ETH_MS_X10 = 25;
    localparam int unsigned ACK_ETH_CYC    = ACK_ETH_MS_X10 * 100 * CLK_MHZ * 1000;
    localparam int unsigned ACK_SER_BITS   = 200;
    localparam int unsigned RST_PULSE_NS   = 10000;
    localparam int unsigned RST_PULSE_CYC  = RST_PULSE_NS * CLK_MHZ / 1000;
    localparam int unsigned DATA_BITS      = 8;
    // Register byte addresses
    localparam logic [7:0] A_CTRL     = 8'h00;
    localparam logic [7:0] A_BAUD     = 8'h04;
    localparam logic [7:0] A_CMD      = 8'h08;
    localparam logic [7:0] A_TXDATA   = 8'h0c;
    localparam logic [7:0] A_RXDATA   = 8'h10;
    localparam logic [7:0] A_STATUS   = 8'h14;
    localparam logic [7:0] A_IRQ_STAT = 8'h18;
    localparam logic [7:0] A_IRQ_MASK = 8'h1c;
    localparam logic [7:0] A_IU_TOUT  = 8'h20;
    localparam logic [7:0] A_ACK_CUR  = 8'h24;
    // CTRL fields
    localparam int unsigned CTRL_ETH  = 0;
    // CMD pulse fields
    localparam int unsigned CMD_SO_TX  = 0;
    localparam int unsigned CMD_SO_RX  = 1;
    localparam int unsigned CMD_AOF    = 2;
    localparam int unsigned CMD_SIGNED = 3;
    localparam int unsigned CMD_DEVRST = 4;
    localparam int unsigned CMD_ACK    = 5;
    localparam int unsigned CMD_FRAME  = 6;
    localparam int unsigned CMD_IU     = 7;
    localparam int unsigned CMD_RREQ   = 8;
    // Interrupt status bits
    localparam int unsigned IRQ_W     = 6;
    localparam int unsigned IRQ_NEX   = 0;
    localparam int unsigned IRQ_RXD   = 1;
    localparam int unsigned IRQ_TXD   = 2;
    localparam int unsigned IRQ_ATO   = 3;
    localparam int unsigned IRQ_FERR  = 4;
    localparam int unsigned IRQ_CLOSE = 5;
    localparam logic [IRQ_W-1:0] IRQ_MASK_RST = 6'h00;
    typedef enum logic [1:0] {
        PST_START   = 2'b00,
        PST_SIGNING = 2'b01,
        PST_SIGNED  = 2'b10
    } adtp_pst_t;
endpackage

// ---- include/adtp_link_if.sv ----
// Pins between the drive end and the automation end
`timescale 1ns/100ps
`default_nettype none
interface adtp_link_if;
    logic host_to_drive;
    logic drive_to_host;
    logic sense_host;
    logic sense_drive;
    logic reset_req;
    modport drive_mp (
        input  host_to_drive,
        input  sense_host,
        input  reset_req,
        output drive_to_host,
        output sense_drive
    );
    modport host_mp (
        input  drive_to_host,
        input  sense_drive,
        output host_to_drive,
        output sense_host,
        output reset_req
    );
endinterface
`default_nettype wire

// ---- hw/adtp_drive_end.sv ----
// Port core shared by both ends, and the drive end
`timescale 1ns/100ps
`default_nettype none
module adtp_port_core
    import adtp_pkg::*;
#(
    parameter logic [15:0] BAUD_DIV_RST = 16'(BAUD_DIV_CYC),
    parameter logic [31:0] ETH_ACK_CYC  = 32'(ACK_ETH_CYC),
    parameter logic [15:0] RST_PULSE    = 16'(RST_PULSE_CYC)
) (
    input  wire logic        i_clk,
    input  wire logic        i_rst,
    input  wire logic        i_psel,
    input  wire logic        i_penable,
    input  wire logic        i_pwrite,
    input  wire logic [7:0]  i_paddr,
    input  wire logic [31:0] i_pwdata,
    output logic      [31:0] o_prdata,
    output logic             o_pready,
    output logic             o_pslverr,
    output logic             o_irq,
    input  wire logic        i_rx,
    input  wire logic        i_present,
    input  wire logic        i_reset_line,
    output logic             o_tx,
    output logic             o_reset_req
);
    generate
        if (BAUD_DIV_RST < 16'h0004 || RST_PULSE == 16'h0000) begin : g_bad
            $error("adtp_port_core: parameter out of range");
        end
    endgenerate

    typedef struct packed {
        logic [2:0]       rx_s;
        logic [2:0]       pr_s;
        logic [2:0]       rs_s;
        logic             rx_f;
        logic             pr_f;
        logic             rs_f;
        adtp_pst_t        pst;
        logic             eth;
        logic [15:0]      div;
        logic [31:0]      ack_cur;
        logic [31:0]      iu_tout;
        logic [31:0]      ack_cnt;
        logic             ack_on;
        logic             dr_pend;
        logic [IRQ_W-1:0] ist;
        logic [IRQ_W-1:0] imask;
        logic             irq;
        logic             tx_on;
        logic [8:0]       tx_sh;
        logic [3:0]       tx_bit;
        logic [15:0]      tx_cnt;
        logic             tx_line;
        logic             rx_on;
        logic [7:0]       rx_sh;
        logic [3:0]       rx_bit;
        logic [15:0]      rx_cnt;
        logic [7:0]       rx_data;
        logic [15:0]      rr_cnt;
        logic             rr_line;
        logic [31:0]      prdata;
        logic             pready;
        logic             pslverr;
    } adtp_core_t;

    adtp_core_t st_reg;
    adtp_core_t st_next;

    always_comb begin
        logic              wr;
        logic [IRQ_W-1:0]  set;
        logic [IRQ_W-1:0]  clr;
        logic              pr_new;
        logic              rs_new;
        logic [31:0]       ser_tout;
        wr       = i_psel & i_penable & i_pwrite & st_reg.pready;
        set      = '0;
        clr      = '0;
        pr_new   = st_reg.pr_f;
        rs_new   = st_reg.rs_f;
        ser_tout = 32'(st_reg.div) * 32'(ACK_SER_BITS);
        st_next  = st_reg;
        // Three-stage pin synchronisers; a change counts once stages two and three agree
        st_next.rx_s = {st_reg.rx_s[1:0], i_rx};
        st_next.pr_s = {st_reg.pr_s[1:0], i_present};
        st_next.rs_s = {st_reg.rs_s[1:0], i_reset_line};
        if (st_reg.rx_s[1] == st_reg.rx_s[2]) begin
            st_next.rx_f = st_reg.rx_s[2];
        end
        if (st_reg.pr_s[1] == st_reg.pr_s[2]) begin
            pr_new = st_reg.pr_s[2];
        end
        if (st_reg.rs_s[1] == st_reg.rs_s[2]) begin
            rs_new = st_reg.rs_s[2];
        end
        st_next.pr_f = pr_new;
        st_next.rs_f = rs_new;
        // APB: answer one cycle after setup, no wait states
        st_next.pready  = i_psel & ~i_penable;
        st_next.pslverr = 1'b0;
        st_next.prdata  = '0;
        if (i_psel & ~i_penable) begin
            unique case (i_paddr)
                A_CTRL:     st_next.prdata = {31'h0, st_reg.eth};
                A_BAUD:     st_next.prdata = {16'h0, st_reg.div};
                A_CMD:      st_next.prdata = '0;
                A_TXDATA:   st_next.prdata = '0;
                A_RXDATA:   st_next.prdata = {24'h0, st_reg.rx_data};
                A_STATUS:   st_next.prdata = {25'h0, st_reg.rr_line, st_reg.dr_pend,
                                              st_reg.ack_on, st_reg.tx_on, st_reg.pr_f,
                                              st_reg.pst};
                A_IRQ_STAT: st_next.prdata = {26'h0, st_reg.ist};
                A_IRQ_MASK: st_next.prdata = {26'h0, st_reg.imask};
                A_IU_TOUT:  st_next.prdata = st_reg.iu_tout;
                A_ACK_CUR:  st_next.prdata = st_reg.ack_cur;
                default:    st_next.pslverr = 1'b1;
            endcase
        end
        if (wr) begin
            unique case (i_paddr)
                A_CTRL: begin
                    st_next.eth     = i_pwdata[CTRL_ETH];
                    st_next.ack_cur = i_pwdata[CTRL_ETH] ? ETH_ACK_CYC : ser_tout;
                end
                A_BAUD: begin
                    if (i_pwdata[15:0] >= 16'h0004) begin
                        st_next.div = i_pwdata[15:0];
                        if (!st_reg.eth) begin
                            st_next.ack_cur = 32'(i_pwdata[15:0]) * 32'(ACK_SER_BITS);
                        end
                    end
                end
                A_CMD: begin
                    if (i_pwdata[CMD_SO_TX] | i_pwdata[CMD_SO_RX]) begin
                        st_next.pst = PST_SIGNING;
                        set[IRQ_NEX] = i_pwdata[CMD_AOF];
                    end
                    if (i_pwdata[CMD_SIGNED] && st_reg.pst == PST_SIGNING) begin
                        st_next.pst = PST_SIGNED;
                    end
                    if (i_pwdata[CMD_DEVRST]) begin
                        st_next.dr_pend = 1'b1;
                    end
                    if (i_pwdata[CMD_ACK]) begin
                        st_next.ack_on = 1'b0;
                        if (st_reg.dr_pend) begin
                            set[IRQ_NEX]    = 1'b1;
                            st_next.dr_pend = 1'b0;
                        end
                    end
                    if (i_pwdata[CMD_FRAME]) begin
                        st_next.ack_on  = 1'b1;
                        st_next.ack_cnt = st_reg.ack_cur;
                    end
                    if (i_pwdata[CMD_IU] && st_reg.eth) begin
                        st_next.ack_cur = st_reg.iu_tout;
                    end
                    if (i_pwdata[CMD_RREQ]) begin
                        st_next.rr_line = 1'b1;
                        st_next.rr_cnt  = RST_PULSE;
                    end
                end
                A_TXDATA: begin
                    if (!st_reg.tx_on) begin
                        st_next.tx_on   = 1'b1;
                        st_next.tx_line = 1'b0;
                        st_next.tx_sh   = {1'b1, i_pwdata[7:0]};
                        st_next.tx_bit  = 4'h0;
                        st_next.tx_cnt  = st_reg.div - 16'h0001;
                    end
                end
                A_IRQ_STAT: clr = i_pwdata[IRQ_W-1:0];
                A_IRQ_MASK: st_next.imask = i_pwdata[IRQ_W-1:0];
                A_IU_TOUT:  st_next.iu_tout = i_pwdata;
                default: begin
                end
            endcase
        end
        // Ack timer
        if (st_reg.ack_on && !(wr && i_paddr == A_CMD)) begin
            if (st_reg.ack_cnt <= 32'h1) begin
                st_next.ack_on = 1'b0;
                set[IRQ_ATO]   = 1'b1;
            end else begin
                st_next.ack_cnt = st_reg.ack_cnt - 32'h1;
            end
        end
        // Reset request pulse
        if (st_reg.rr_line && !(wr && i_paddr == A_CMD)) begin
            if (st_reg.rr_cnt == 16'h0001) begin
                st_next.rr_line = 1'b0;
            end
            st_next.rr_cnt = st_reg.rr_cnt - 16'h0001;
        end
        // Reset line rising: reset indication
        if (rs_new & ~st_reg.rs_f) begin
            set[IRQ_NEX] = 1'b1;
        end
        // Presence lost: close event
        if (st_reg.pr_f & ~pr_new) begin
            set[IRQ_CLOSE] = 1'b1;
            if (st_reg.pst != PST_START) begin
                set[IRQ_NEX] = 1'b1;
            end
            st_next.pst = PST_START;
        end
        // Transmitter: start, 8 data LSB first, stop, NRZ one bit per baud
        if (st_reg.tx_on) begin
            if (st_reg.tx_cnt == 16'h0000) begin
                st_next.tx_cnt = st_reg.div - 16'h0001;
                if (st_reg.tx_bit == 4'h9) begin
                    st_next.tx_on = 1'b0;
                    set[IRQ_TXD]  = 1'b1;
                end else begin
                    st_next.tx_line = st_reg.tx_sh[0];
                    st_next.tx_sh   = {1'b1, st_reg.tx_sh[8:1]};
                    st_next.tx_bit  = st_reg.tx_bit + 4'h1;
                end
            end else begin
                st_next.tx_cnt = st_reg.tx_cnt - 16'h0001;
            end
        end
        // Receiver: sample mid-bit, check start and stop
        if (!st_reg.rx_on) begin
            if (!st_reg.rx_f) begin
                st_next.rx_on  = 1'b1;
                st_next.rx_bit = 4'h0;
                st_next.rx_cnt = {1'b0, st_reg.div[15:1]};
            end
        end else if (st_reg.rx_cnt == 16'h0000) begin
            st_next.rx_cnt = st_reg.div - 16'h0001;
            st_next.rx_bit = st_reg.rx_bit + 4'h1;
            if (st_reg.rx_bit == 4'h0) begin
                st_next.rx_on = ~st_reg.rx_f;
            end else if (st_reg.rx_bit == 4'h9) begin
                st_next.rx_on = 1'b0;
                if (st_reg.rx_f) begin
                    st_next.rx_data = st_reg.rx_sh;
                    set[IRQ_RXD]    = 1'b1;
                end else begin
                    set[IRQ_FERR]   = 1'b1;
                end
            end else begin
                st_next.rx_sh = {st_reg.rx_f, st_reg.rx_sh[7:1]};
            end
        end else begin
            st_next.rx_cnt = st_reg.rx_cnt - 16'h0001;
        end
        // Sticky status: a set in the same cycle as a clear wins
        st_next.ist = (st_reg.ist & ~clr) | set;
        st_next.irq = |(st_next.ist & st_next.imask);
    end

    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            st_reg         <= '0;
            st_reg.rx_s    <= 3'h7;
            st_reg.rx_f    <= 1'b1;
            st_reg.tx_line <= 1'b1;
            st_reg.pst     <= PST_START;
            st_reg.div     <= BAUD_DIV_RST;
            st_reg.ack_cur <= 32'(BAUD_DIV_RST) * 32'(ACK_SER_BITS);
            st_reg.imask   <= IRQ_MASK_RST;
        end else begin
            st_reg <= st_next;
        end
    end

    assign o_prdata    = st_reg.prdata;
    assign o_pready    = st_reg.pready;
    assign o_pslverr   = st_reg.pslverr;
    assign o_irq       = st_reg.irq;
    assign o_tx        = st_reg.tx_line;
    assign o_reset_req = st_reg.rr_line;
endmodule

module adtp_drive_end
    import adtp_pkg::*;
#(
    parameter logic [15:0] BAUD_DIV_RST = 16'(BAUD_DIV_CYC),
    parameter logic [31:0] ETH_ACK_CYC  = 32'(ACK_ETH_CYC)
) (
    input  wire logic        I_CLK,
    input  wire logic        I_RST,
    input  wire logic        I_PSEL,
    input  wire logic        I_PENABLE,
    input  wire logic        I_PWRITE,
    input  wire logic [7:0]  I_PADDR,
    input  wire logic [31:0] I_PWDATA,
    output logic      [31:0] O_PRDATA,
    output logic             O_PREADY,
    output logic             O_PSLVERR,
    output logic             O_IRQ,
    adtp_link_if.drive_mp    link
);
    typedef struct packed {
        logic sense;
    } adtp_drv_t;

    adtp_drv_t drv_reg;
    adtp_drv_t drv_next;

    always_comb begin
        drv_next       = drv_reg;
        drv_next.sense = 1'b1;
    end

    always_ff @(posedge I_CLK or posedge I_RST) begin
        if (I_RST) begin
            drv_reg <= '0;
        end else begin
            drv_reg <= drv_next;
        end
    end

    assign link.sense_drive = drv_reg.sense;

    adtp_port_core #(
        .BAUD_DIV_RST (BAUD_DIV_RST),
        .ETH_ACK_CYC  (ETH_ACK_CYC),
        .RST_PULSE    (16'(RST_PULSE_CYC))
    ) u_core (
        .i_clk        (I_CLK),
        .i_rst        (I_RST),
        .i_psel       (I_PSEL),
        .i_penable    (I_PENABLE),
        .i_pwrite     (I_PWRITE),
        .i_paddr      (I_PADDR),
        .i_pwdata     (I_PWDATA),
        .o_prdata     (O_PRDATA),
        .o_pready     (O_PREADY),
        .o_pslverr    (O_PSLVERR),
        .o_irq        (O_IRQ),
        .i_rx         (link.host_to_drive),
        .i_present    (link.sense_host),
        .i_reset_line (link.reset_req),
        .o_tx         (link.drive_to_host),
        .o_reset_req  ()
    );
endmodule
`default_nettype wire

// ---- hw/adtp_host_end.sv ----
// Automation device end of the serial port link
`timescale 1ns/100ps
`default_nettype none
module adtp_host_end
    import adtp_pkg::*;
#(
    parameter logic [15:0] BAUD_DIV_RST = 16'(BAUD_DIV_CYC),
    parameter logic [31:0] ETH_ACK_CYC  = 32'(ACK_ETH_CYC),
    parameter logic [15:0] RST_PULSE    = 16'(RST_PULSE_CYC)
) (
    input  wire logic        I_CLK,
    input  wire logic        I_RST,
    input  wire logic        I_PSEL,
    input  wire logic        I_PENABLE,
    input  wire logic        I_PWRITE,
    input  wire logic [7:0]  I_PADDR,
    input  wire logic [31:0] I_PWDATA,
    output logic      [31:0] O_PRDATA,
    output logic             O_PREADY,
    output logic             O_PSLVERR,
    output logic             O_IRQ,
    adtp_link_if.host_mp     link
);
    typedef struct packed {
        logic sense;
    } adtp_hst_t;

    adtp_hst_t hst_reg;
    adtp_hst_t hst_next;

    always_comb begin
        hst_next       = hst_reg;
        hst_next.sense = 1'b1;
    end

    always_ff @(posedge I_CLK or posedge I_RST) begin
        if (I_RST) begin
            hst_reg <= '0;
        end else begin
            hst_reg <= hst_next;
        end
    end

    assign link.sense_host = hst_reg.sense;

    // No reset line reaches this end, so its reset input is held low
    adtp_port_core #(
        .BAUD_DIV_RST (BAUD_DIV_RST),
        .ETH_ACK_CYC  (ETH_ACK_CYC),
        .RST_PULSE    (RST_PULSE)
    ) u_core (
        .i_clk        (I_CLK),
        .i_rst        (I_RST),
        .i_psel       (I_PSEL),
        .i_penable    (I_PENABLE),
        .i_pwrite     (I_PWRITE),
        .i_paddr      (I_PADDR),
        .i_pwdata     (I_PWDATA),
        .o_prdata     (O_PRDATA),
        .o_pready     (O_PREADY),
        .o_pslverr    (O_PSLVERR),
        .o_irq        (O_IRQ),
        .i_rx         (link.drive_to_host),
        .i_present    (link.sense_drive),
        .i_reset_line (1'b0),
        .o_tx         (link.host_to_drive),
        .o_reset_req  (link.reset_req)
    );
endmodule
`default_nettype wire

// ---- testbench/adtp_link_sva.sv ----
// Assertions on the link pins between the drive end and the automation end
`timescale 1ns/100ps
`default_nettype none
module adtp_link_sva #(
    parameter int unsigned BD = 16
) (
    input wire logic I_CLK,
    input wire logic i_rst_drive,
    input wire logic i_rst_host,
    input wire logic host_to_drive,
    input wire logic drive_to_host,
    input wire logic sense_host,
    input wire logic sense_drive,
    input wire logic reset_req
);
    int unsigned fc;
    // Cycle position inside a host lane character, 0 between characters
    always_ff @(posedge I_CLK or posedge i_rst_host) begin
        if (i_rst_host) begin
            fc <= 0;
        end else if (fc == 0 && !host_to_drive) begin
            fc <= 1;
        end else if (fc != 0) begin
            fc <= (fc == 10 * BD - 1) ? 0 : fc + 1;
        end
    end
    default clocking cb @(posedge I_CLK); endclocking
    default disable iff (i_rst_drive || i_rst_host);
    a_start_bit_low: assert property (fc != 0 && fc < BD |-> !host_to_drive)
        else $error("start bit not low for a full bit");
    a_bit_steady: assert property (fc != 0 && fc % BD != 0 |-> $stable(host_to_drive))
        else $error("lane changed inside a bit");
    a_stop_bit_high: assert property (fc >= 9 * BD |-> host_to_drive)
        else $error("stop bit not high");
    a_idle_high: assert property (fc == 0 && !host_to_drive |-> $past(host_to_drive))
        else $error("lane low between characters");
    a_d2h_low_min: assert property ($fell(drive_to_host) |-> !drive_to_host [*8])
        else $error("drive lane low level too short");
    a_d2h_high_min: assert property ($rose(drive_to_host) |-> drive_to_host [*8])
        else $error("drive lane high level too short");
    a_rreq_pulse: assert property ($rose(reset_req) |-> reset_req [*8] ##1 !reset_req)
        else $error("reset request pulse length wrong");
    a_drive_present: assert property (!$past(i_rst_drive) |-> sense_drive)
        else $error("drive presence not shown");
    a_host_present: assert property (!$past(i_rst_host) |-> sense_host)
        else $error("host presence not shown");
    c_frame: cover property (fc == 10 * BD - 1);
    c_rreq: cover property ($rose(reset_req));
    c_close: cover property (disable iff (i_rst_drive) $fell(sense_host));
endmodule
`default_nettype wire

// ---- testbench/adt_serial_port_link_events_tb.sv ----
// Bench joining the drive end and the automation end back to back
`timescale 1ns/100ps
`default_nettype none
module adt_serial_port_link_events_tb;
    import adtp_pkg::*;
    localparam int BD = 16;
    logic        clk = 0;
    logic  [1:0] rst = 2'b11;
    logic  [1:0] psel = 0;
    logic  [1:0] pen = 0;
    logic  [1:0] rdy;
    logic  [1:0] err;
    logic  [1:0] irq;
    logic        pw = 0;
    logic        pe;
    logic  [7:0] pa = 0;
    logic [31:0] pd = 0;
    logic [31:0] r;
    logic [31:0] rd [2];
    int          fails = 0;
    int          comparisons = 0;
    always #2.5 clk = ~clk;
    adtp_link_if link ();
    adtp_drive_end #(.BAUD_DIV_RST(16'd16), .ETH_ACK_CYC(32'd100)) adtp_drive_end_i (
        .I_CLK(clk), .I_RST(rst[0]), .I_PSEL(psel[0]), .I_PENABLE(pen[0]), .I_PWRITE(pw),
        .I_PADDR(pa), .I_PWDATA(pd), .O_PRDATA(rd[0]), .O_PREADY(rdy[0]),
        .O_PSLVERR(err[0]), .O_IRQ(irq[0]), .link(link.drive_mp));
    adtp_host_end #(.BAUD_DIV_RST(16'd16), .ETH_ACK_CYC(32'd100), .RST_PULSE(16'd8))
        adtp_host_end_i (
        .I_CLK(clk), .I_RST(rst[1]), .I_PSEL(psel[1]), .I_PENABLE(pen[1]), .I_PWRITE(pw),
        .I_PADDR(pa), .I_PWDATA(pd), .O_PRDATA(rd[1]), .O_PREADY(rdy[1]),
        .O_PSLVERR(err[1]), .O_IRQ(irq[1]), .link(link.host_mp));
    adtp_link_sva #(.BD(BD)) adtp_link_sva_i (
        .I_CLK(clk), .i_rst_drive(rst[0]), .i_rst_host(rst[1]),
        .host_to_drive(link.host_to_drive), .drive_to_host(link.drive_to_host),
        .sense_host(link.sense_host), .sense_drive(link.sense_drive),
        .reset_req(link.reset_req));
    task automatic conclude();
        $display("comparisons %0d fails %0d", comparisons, fails);
        if (fails == 0 && comparisons > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask
    task automatic chk(input string n, input logic [31:0] s, input logic [31:0] x);
        comparisons++;
        if (s !== x) begin
            fails++;
            $display("[ERR] %s expected %h seen %h", n, x, s);
        end
    endtask
    // One APB transfer on end e (0 drive, 1 host); read data lands in r
    task automatic bus(input int e, input logic w, input logic [7:0] a, input logic [31:0] d);
        int n;
        n = 0;
        psel[e] <= 1'b1;
        pw <= w;
        pa <= a;
        pd <= d;
        @(posedge clk);
        pen[e] <= 1'b1;
        do begin
            @(posedge clk);
            n++;
        end while (rdy[e] !== 1'b1 && n < 50);
        if (rdy[e] !== 1'b1) begin
            fails++;
            conclude();
        end
        r = rd[e];
        pe = err[e];
        psel[e] <= 1'b0;
        pen[e] <= 1'b0;
        @(posedge clk);
    endtask
    task automatic wait_irq(input int e, input int b);
        int n;
        n = 0;
        do begin
            bus(e, 0, A_IRQ_STAT, 0);
            n++;
        end while (r[b] !== 1'b1 && n < 400);
        if (r[b] !== 1'b1) begin
            fails++;
            conclude();
        end
    endtask
    task automatic t_regs();
        bus(0, 0, A_ACK_CUR, 0);
        chk("ack_cur", r, 32'd3200);
        bus(0, 0, A_IRQ_MASK, 0);
        chk("mask", r, 32'h0);
        for (int e = 0; e < 2; e++) begin
            bus(e, 0, A_STATUS, 0);
            chk("status", 32'(r[2:0]), 32'h4);
            bus(e, 0, 8'h28, 0);
            chk("unmapped", 32'(pe), 32'h1);
        end
    endtask
    task automatic t_byte(input int e, input logic [7:0] b);
        logic [9:0] f;
        f = {1'b1, b, 1'b0};
        bus(1 - e, 1, A_IRQ_MASK, 32'h2);
        bus(e, 1, A_TXDATA, {24'h0, b});
        repeat (BD / 2 - 1) @(posedge clk);
        for (int k = 0; k < 10; k++) begin
            chk("lane", 32'(e ? link.host_to_drive : link.drive_to_host), 32'(f[k]));
            chk("other lane", 32'(e ? link.drive_to_host : link.host_to_drive), 32'h1);
            repeat (BD) @(posedge clk);
        end
        wait_irq(1 - e, IRQ_RXD);
        chk("irq", 32'(irq[1 - e]), 32'h1);
        bus(1 - e, 0, A_RXDATA, 0);
        chk("rx byte", r, {24'h0, b});
        bus(1 - e, 1, A_IRQ_STAT, 32'h3f);
        bus(1 - e, 0, A_IRQ_STAT, 0);
        chk("irq clear", 32'(irq[1 - e]), 32'h0);
    endtask
    task automatic t_nexus();
        logic [31:0] c [6] = '{32'h5, 32'h1, 32'h6, 32'h20, 32'h10, 32'h20};
        logic        x [6] = '{1'b1, 1'b0, 1'b1, 1'b0, 1'b0, 1'b1};
        for (int k = 0; k < 6; k++) begin
            bus(0, 1, A_CMD, c[k]);
            bus(0, 0, A_IRQ_STAT, 0);
            chk("nexus", 32'(r[IRQ_NEX]), 32'(x[k]));
            bus(0, 1, A_IRQ_STAT, 32'h3f);
        end
    endtask
    task automatic t_close(input logic [31:0] c1, input logic [31:0] c2, input logic nx);
        bus(0, 1, A_CMD, c1);
        bus(0, 1, A_CMD, c2);
        rst[1] <= 1'b1;
        wait_irq(0, IRQ_CLOSE);
        chk("close nexus", 32'(r[IRQ_NEX]), 32'(nx));
        bus(0, 0, A_STATUS, 0);
        chk("state", 32'(r[1:0]), 32'(PST_START));
        bus(0, 1, A_IRQ_STAT, 32'h3f);
        rst[1] <= 1'b0;
        repeat (10) @(posedge clk);
    endtask
    task automatic t_ack();
        bus(0, 1, A_BAUD, 32'd20);
        bus(0, 0, A_ACK_CUR, 0);
        chk("ack serial", r, 32'd4000);
        bus(0, 1, A_IU_TOUT, 32'd60);
        bus(0, 1, A_CMD, 32'h80);
        bus(0, 0, A_ACK_CUR, 0);
        chk("ack unit serial", r, 32'd4000);
        bus(0, 1, A_CTRL, 32'h1);
        bus(0, 0, A_ACK_CUR, 0);
        chk("ack eth", r, 32'd100);
        bus(0, 1, A_CMD, 32'h80);
        bus(0, 0, A_ACK_CUR, 0);
        chk("ack unit", r, 32'd60);
        bus(0, 1, A_CMD, 32'h40);
        bus(0, 0, A_IRQ_STAT, 0);
        chk("ack early", 32'(r[IRQ_ATO]), 32'h0);
        wait_irq(0, IRQ_ATO);
    endtask
    initial begin
        repeat (2) @(posedge clk);
        rst <= 2'b00;
        repeat (8) @(posedge clk);
        t_regs();
        t_byte(1, 8'ha5);
        t_byte(0, 8'h3c);
        t_nexus();
        bus(1, 1, A_CMD, 32'h100);
        wait_irq(0, IRQ_NEX);
        bus(0, 1, A_IRQ_STAT, 32'h3f);
        t_close(32'h1, 32'h0, 1'b1);
        t_close(32'h0, 32'h0, 1'b0);
        t_close(32'h1, 32'h8, 1'b1);
        t_ack();
        conclude();
    end
endmodule
`default_nettype wire
